// ==== src/oid_params.svh ====
// Functional notes
// - Module uses two input bytes and two output bytes for eight channels.
// - Input byte zero bit n carries signal state of channel n plus one.
// - Input byte one bit n carries fault flag of channel n plus one.
// - Output byte one bit n: 0 keeps channel on, 1 switches it off.
// - Image word is little endian: byte zero in the low byte lane.
`ifndef OID_PARAMS_SVH
`define OID_PARAMS_SVH
`define OID_ADDR_W        2
`define OID_OFS_INPUT     2'h0
`define OID_OFS_OUTPUT    2'h1
`define OID_BYTE0_LSB     0
`define OID_BYTE1_LSB     8
`define OID_CHANNELS      8
`define OID_SWITCH_RESET  8'h00
`define OID_UNMAPPED_DATA 32'h00000000
`endif

// ==== src/oid_pkg.sv ====
package oid_pkg;
  typedef enum logic [1:0] {
    OID_IDLE = 2'b01,
    OID_DONE = 2'b10
  } oid_bus_state_t;
endpackage

// ==== src/oid_sync_reg.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "oid_params.svh"
// Registers the raw channel inputs so the image shows one coherent sample.
module oid_sync_reg #(
  parameter int WIDTH = `OID_CHANNELS
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] q_reg;
  logic [WIDTH-1:0] q_next;

  always_comb begin
    q_next = d_in;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign q_out = q_reg;
endmodule
`default_nettype wire

// ==== src/oid_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "oid_params.svh"
module oid_top
  import oid_pkg::*;
#(
  parameter int CHANNELS = `OID_CHANNELS
) (
  // Clock and reset.
  input  wire logic                  MCLK_IN,
  input  wire logic                  SYS_RST_IN,
  // Avalon-MM slave.
  input  wire logic [`OID_ADDR_W-1:0] AVS_ADDRESS_IN,
  input  wire logic                  AVS_READ_IN,
  input  wire logic                  AVS_WRITE_IN,
  input  wire logic [31:0]           AVS_WRITEDATA_IN,
  input  wire logic [3:0]            AVS_BYTEENABLE_IN,
  output logic      [31:0]           AVS_READDATA_OUT,
  output logic                       AVS_WAITREQUEST_OUT,
  // Field side.
  input  wire logic [CHANNELS-1:0]   CHANNEL_STATE_IN,
  input  wire logic [CHANNELS-1:0]   CHANNEL_FAULT_IN,
  output logic      [CHANNELS-1:0]   CHANNEL_OFF_OUT
);
  // The image bytes are eight bits wide, so no other channel count fits.
  if (CHANNELS != 8) begin : g_bad_channels
    $error("oid_top supports exactly eight channels.");
  end

  logic [CHANNELS-1:0] state_s;
  logic [CHANNELS-1:0] fault_s;
  logic [2*CHANNELS-1:0] sample_s;
  oid_bus_state_t      bus_reg;
  oid_bus_state_t      bus_next;
  logic [31:0]         rdata_reg;
  logic [31:0]         rdata_next;
  logic [7:0]          switch_reg;
  logic [7:0]          switch_next;

  oid_sync_reg #(.WIDTH(2*CHANNELS)) u_sample (
    .clk_in (MCLK_IN),
    .rst_in (SYS_RST_IN),
    .d_in   ({CHANNEL_FAULT_IN, CHANNEL_STATE_IN}),
    .q_out  (sample_s)
  );

  assign state_s = sample_s[CHANNELS-1:0];
  assign fault_s = sample_s[2*CHANNELS-1:CHANNELS];

  // Two bytes per direction packed little endian into one word.
  function automatic logic [31:0] pack_word(input logic [7:0] b0,
                                            input logic [7:0] b1);
    pack_word = {16'h0000, b1, b0};
  endfunction

  // Every access waits one cycle so read data come from a register.
  always_comb begin
    bus_next    = bus_reg;
    rdata_next  = rdata_reg;
    switch_next = switch_reg;
    case (bus_reg)
      OID_IDLE: begin
        if (AVS_READ_IN || AVS_WRITE_IN) begin
          bus_next = OID_DONE;
        end
        if (AVS_READ_IN) begin
          case (AVS_ADDRESS_IN)
            `OID_OFS_INPUT:  rdata_next = pack_word(state_s, fault_s);
            `OID_OFS_OUTPUT: rdata_next = pack_word(8'h00, switch_reg);
            default:         rdata_next = `OID_UNMAPPED_DATA;
          endcase
        end
      end
      OID_DONE: begin
        bus_next = OID_IDLE;
        // Commit on the edge where the master sees waitrequest low.
        // Byte zero is reserved, so only lane one is stored.
        if (AVS_WRITE_IN && AVS_ADDRESS_IN == `OID_OFS_OUTPUT &&
            AVS_BYTEENABLE_IN[1]) begin
          switch_next = AVS_WRITEDATA_IN[`OID_BYTE1_LSB +: 8];
        end
      end
      default: begin
        bus_next = OID_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      bus_reg    <= OID_IDLE;
      rdata_reg  <= 32'h00000000;
      switch_reg <= `OID_SWITCH_RESET;
    end else begin
      bus_reg    <= bus_next;
      rdata_reg  <= rdata_next;
      switch_reg <= switch_next;
    end
  end

  assign AVS_WAITREQUEST_OUT = (AVS_READ_IN || AVS_WRITE_IN) &&
                               (bus_reg != OID_DONE);
  assign AVS_READDATA_OUT    = rdata_reg;
  assign CHANNEL_OFF_OUT     = switch_reg;
endmodule
`default_nettype wire

// ==== verification/oid_field_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module oid_field (
  input  wire logic [7:0] want_state_in,
  input  wire logic [7:0] want_fault_in,
  input  wire logic [7:0] off_in,
  output logic      [7:0] state_out,
  output logic      [7:0] fault_out
);
  // An off channel reads low, so the switch shows up in the image.
  assign state_out = want_state_in & ~off_in;
  assign fault_out = want_fault_in;
endmodule
`default_nettype wire

// ==== verification/oid_properties.sv ====
`timescale 1ns/1ns
`default_nettype none
module oid_chk (
  input wire logic        MCLK_IN,
  input wire logic        SYS_RST_IN,
  input wire logic [1:0]  AVS_ADDRESS_IN,
  input wire logic        AVS_READ_IN,
  input wire logic        AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  input wire logic [3:0]  AVS_BYTEENABLE_IN,
  input wire logic [31:0] AVS_READDATA_OUT,
  input wire logic        AVS_WAITREQUEST_OUT,
  input wire logic [7:0]  CHANNEL_STATE_IN,
  input wire logic [7:0]  CHANNEL_FAULT_IN,
  input wire logic [7:0]  CHANNEL_OFF_OUT
);
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  wire rd = AVS_READ_IN && !AVS_WAITREQUEST_OUT;
  wire wd = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT;
  AST_HIGH_ZERO: assert property (rd |-> AVS_READDATA_OUT[31:16] == 16'h0000)
    else $error("upper half of a read not zero");
  AST_STATE: assert property (rd && AVS_ADDRESS_IN == 2'h0 && $past(CHANNEL_STATE_IN, 3) == CHANNEL_STATE_IN && $stable(CHANNEL_STATE_IN) |-> AVS_READDATA_OUT[7:0] == CHANNEL_STATE_IN)
    else $error("state byte wrong");
  AST_FAULT: assert property (rd && AVS_ADDRESS_IN == 2'h0 && $past(CHANNEL_FAULT_IN, 3) == CHANNEL_FAULT_IN && $stable(CHANNEL_FAULT_IN) |-> AVS_READDATA_OUT[15:8] == CHANNEL_FAULT_IN)
    else $error("fault byte wrong");
  AST_OFF_WR: assert property (wd && AVS_ADDRESS_IN == 2'h1 && AVS_BYTEENABLE_IN[1] |=> CHANNEL_OFF_OUT == $past(AVS_WRITEDATA_IN[15:8]))
    else $error("switch-off not taken");
  AST_OFF_HOLD: assert property (!AVS_WRITE_IN |=> $stable(CHANNEL_OFF_OUT))
    else $error("switch-off moved without write");
  AST_OUT_WORD: assert property (rd && AVS_ADDRESS_IN == 2'h1 |-> AVS_READDATA_OUT[15:0] == {CHANNEL_OFF_OUT, 8'h00})
    else $error("output word lanes wrong");
  cover property (rd && AVS_ADDRESS_IN == 2'h0);
  cover property (wd && AVS_ADDRESS_IN == 2'h1);
  cover property (rd && AVS_ADDRESS_IN == 2'h3);
endmodule
bind oid_top oid_chk u_chk (.*);
`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        clk = 0, rst = 1, rd = 0, wr = 0, wq;
  logic [1:0]  ad = 0;
  logic [3:0]  be = 0;
  logic [31:0] wd = 0, rdat, q;
  logic [7:0]  st, ft, off, ws = 0, wf = 0;
  int          checks = 0, miscompares = 0;
  oid_top dut (.MCLK_IN(clk), .SYS_RST_IN(rst), .AVS_ADDRESS_IN(ad),
    .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd),
    .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdat),
    .AVS_WAITREQUEST_OUT(wq), .CHANNEL_STATE_IN(st),
    .CHANNEL_FAULT_IN(ft), .CHANNEL_OFF_OUT(off));
  oid_field fm (.want_state_in(ws), .want_fault_in(wf), .off_in(off),
    .state_out(st), .fault_out(ft));
  initial forever #20 clk = ~clk;
  task automatic bus(input logic w, input logic [1:0] a,
                     input logic [31:0] d, input logic [3:0] e);
    @(posedge clk);
    rd <= !w; wr <= w; ad <= a; wd <= d; be <= e;
    do @(posedge clk); while (wq !== 1'b0);
    q = rdat;
    rd <= 0; wr <= 0;
  endtask
  task automatic chk(input string n, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    test_done;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 0; ws <= 8'h81; wf <= 8'h3C;
    repeat (3) @(posedge clk);
    bus(0, 0, 0, 4'hF); chk("in_word", q, 32'h00003C81);
    bus(1, 1, 32'h0000A500, 4'hF);
    bus(0, 1, 0, 4'hF); chk("out_word", q, 32'h0000A500);
    chk("off_pins", {24'h0, off}, 32'h000000A5);
    bus(1, 1, 32'h0000FF00, 4'h1);
    bus(0, 1, 0, 4'hF); chk("lane_mask", q, 32'h0000A500);
    ws <= 8'hFF;
    repeat (4) @(posedge clk);
    bus(0, 0, 0, 4'hF); chk("off_effect", q, 32'h00003C5A);
    bus(0, 3, 0, 4'hF); chk("unmapped", q, 32'h00000000);
    test_done;
  end
endmodule
`default_nettype wire
